// file: design/windowed_supervisor.sv
// Windowed supervisor: prescaled 24-bit down counter, feed check, APB slave
// Functional notes
// - Reset chip when not fed before time-out
// - In window mode accept feed only inside window
// - Warning interrupt programmable time before time-out
// - Enable sticks until reset or supervisor event
// - Bad feed causes reset, or interrupt mode
// - Readable flag: last reset came from supervisor
// - 24-bit counter behind an internal prescaler
// - Time-out 256x4 to 2^24x4 ticks, steps of 4
// - Tick comes from the supervisor oscillator
//
// Design decisions made here: the APB register port and the address map.
`default_nettype none
module windowed_supervisor
  import windowed_supervisor_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Oscillator pin, asynchronous to clk_sys
  input wire logic supervisor_oscillator,
  // APB slave
  input wire apb_req_s apb_req,
  output var apb_rsp_s apb_rsp,
  // Events
  output logic irq,
  output logic chip_reset
);

  sup_state_s st;
  sup_state_s nx;
  logic osc_edge;
  logic tick;
  logic setup;
  logic acc;
  logic wr;
  logic feed_wr;
  logic key1;
  logic key2;
  logic in_window;
  logic good_feed;
  logic bad_feed;
  logic timeout_evt;
  logic fault;

  function automatic logic [31:0] widen(input logic [23:0] v);
    return {8'h00, v};
  endfunction

  // Second and third sync stages only; the first is never looked at
  assign osc_edge = st.sync[1] & ~st.sync[2];
  assign tick = osc_edge & st.en & (st.pre == PRESCALE_LAST);
  assign setup = apb_req.psel & ~apb_req.penable & ~st.rsp.pready;
  assign acc = apb_req.psel & apb_req.penable & st.rsp.pready;
  assign wr = acc & apb_req.pwrite;
  assign feed_wr = wr & (apb_req.paddr == OFF_FEED);
  assign key1 = feed_wr & (apb_req.pwdata == FEED_KEY1);
  assign key2 = st.armed & feed_wr & (apb_req.pwdata == FEED_KEY2);
  assign in_window = st.count <= st.window;
  assign good_feed = key2 & in_window;
  // Any completed access while armed, other than the second key inside the window, breaks the feed
  assign bad_feed = acc & ~good_feed & (st.armed | (feed_wr & ~key1));
  assign timeout_evt = tick & (st.count == 24'h000000);
  assign fault = st.en & (timeout_evt | bad_feed);

  always_comb begin
    nx = st;
    nx.sync = {st.sync[1:0], supervisor_oscillator};
    nx.chip_reset = 1'b0;

    // APB: answer registered during setup, one wait-free access cycle
    nx.rsp.pready = setup;
    if (setup) begin
      nx.rsp.pslverr = 1'b0;
      case (apb_req.paddr)
        OFF_MODE: nx.rsp.prdata = {30'h0, st.mode_irq, st.en};
        OFF_TIMEOUT: nx.rsp.prdata = widen(st.timeout);
        OFF_FEED: nx.rsp.prdata = 32'h00000000;
        OFF_COUNT: nx.rsp.prdata = widen(st.count);
        OFF_WARN: nx.rsp.prdata = widen(st.warn);
        OFF_WINDOW: nx.rsp.prdata = widen(st.window);
        OFF_STATUS: nx.rsp.prdata = {28'h0, st.status};
        OFF_MASK: nx.rsp.prdata = {28'h0, st.mask};
        default: begin
          nx.rsp.prdata = 32'h00000000;
          nx.rsp.pslverr = 1'b1;
        end
      endcase
    end

    if (wr) begin
      case (apb_req.paddr)
        OFF_MODE: begin
          nx.en = st.en | apb_req.pwdata[MODE_EN];
          // Mode locked once running so software cannot dodge the reset
          if (!st.en) begin
            nx.mode_irq = apb_req.pwdata[MODE_IRQ];
          end
        end
        OFF_TIMEOUT: begin
          if (apb_req.pwdata[23:0] < TIMEOUT_MIN) begin
            nx.timeout = TIMEOUT_MIN;
          end else begin
            nx.timeout = apb_req.pwdata[23:0];
          end
        end
        OFF_WARN: nx.warn = apb_req.pwdata[23:0];
        OFF_WINDOW: nx.window = apb_req.pwdata[23:0];
        OFF_STATUS: nx.status = st.status & ~apb_req.pwdata[3:0];
        OFF_MASK: nx.mask = apb_req.pwdata[3:0];
        default: ;
      endcase
    end

    if (acc) begin
      nx.armed = ~st.armed & key1;
    end

    // Prescaler runs on oscillator edges only while enabled
    if (!st.en) begin
      nx.pre = 2'h0;
    end else if (osc_edge) begin
      nx.pre = 2'(st.pre + 2'h1);
    end

    if (good_feed) begin
      nx.count = st.timeout;
    end else if (tick && st.count != 24'h000000) begin
      nx.count = 24'(st.count - 24'h000001);
      if (24'(st.count - 24'h000001) == st.warn) begin
        nx.status[ST_WARN] = 1'b1;
      end
    end

    if (fault) begin
      nx.en = 1'b0;
      nx.pre = 2'h0;
      nx.armed = 1'b0;
      nx.count = st.timeout;
      if (st.mode_irq) begin
        if (timeout_evt) begin
          nx.status[ST_TIMEOUT] = 1'b1;
        end
        if (bad_feed) begin
          nx.status[ST_FEED_ERR] = 1'b1;
        end
      end else begin
        // Chip reset: configuration except the mask back to defaults, flag survives
        nx.chip_reset = 1'b1;
        nx.status[ST_WD_RESET] = 1'b1;
        nx.mode_irq = 1'b0;
        nx.timeout = TIMEOUT_RST;
        nx.count = TIMEOUT_RST;
        nx.warn = WARN_RST;
        nx.window = WINDOW_RST;
      end
    end

    nx.irq = |(nx.status & nx.mask);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st <= '{sync: 3'h0, pre: 2'h0, count: TIMEOUT_RST, timeout: TIMEOUT_RST,
             warn: WARN_RST, window: WINDOW_RST, en: 1'b0, mode_irq: 1'b0,
             armed: 1'b0, status: STATUS_RST, mask: MASK_RST,
             rsp: '{prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0},
             irq: 1'b0, chip_reset: 1'b0};
    end else begin
      st <= nx;
    end
  end

  assign apb_rsp = st.rsp;
  assign irq = st.irq;
  assign chip_reset = st.chip_reset;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence s_expire_reset;
    st.en && !st.mode_irq && timeout_evt;
  endsequence
  sequence s_bad_reset;
    st.en && !st.mode_irq && bad_feed;
  endsequence
  sequence s_pulse_once;
    chip_reset ##1 !chip_reset;
  endsequence

  property p_expire_reset;
    s_expire_reset |=> s_pulse_once;
  endproperty
  a_expire_reset: assert property (p_expire_reset)
    else $error("time-out did not pulse chip_reset");

  property p_early_feed;
    st.en && key2 && (st.count > st.window) |=> !st.en && (st.status[ST_FEED_ERR] || chip_reset);
  endproperty
  a_early_feed: assert property (p_early_feed)
    else $error("feed before window was accepted");

  property p_warn;
    tick && st.count != 24'h000000 && 24'(st.count - 24'h000001) == st.warn && !good_feed
      |=> st.status[ST_WARN] && (irq || !st.mask[ST_WARN]);
  endproperty
  a_warn: assert property (p_warn)
    else $error("warning flag not raised");

  property p_enable_sticks;
    st.en && !fault |=> st.en;
  endproperty
  a_enable_sticks: assert property (p_enable_sticks)
    else $error("supervisor disabled without event");

  property p_bad_reset;
    s_bad_reset |=> chip_reset ##1 !chip_reset;
  endproperty
  a_bad_reset: assert property (p_bad_reset)
    else $error("bad feed did not reset");

  property p_flag;
    chip_reset |-> st.status[ST_WD_RESET] && !st.en;
  endproperty
  a_flag: assert property (p_flag)
    else $error("reset flag missing after supervisor reset");

  property p_prescale_hold;
    st.en && !osc_edge && !good_feed && !fault |=> $stable(st.count) && $stable(st.pre);
  endproperty
  a_prescale_hold: assert property (p_prescale_hold)
    else $error("counter moved without oscillator edge");

  property p_timeout_min;
    st.timeout >= TIMEOUT_MIN;
  endproperty
  a_timeout_min: assert property (p_timeout_min)
    else $error("time-out below minimum");

  property p_decrement;
    tick && st.count != 24'h000000 && !good_feed && !fault
      |=> st.count == 24'($past(st.count) - 24'h000001);
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("counter did not step down");

  property p_reload;
    good_feed && !fault |=> st.count == $past(st.timeout) && !st.armed;
  endproperty
  a_reload: assert property (p_reload)
    else $error("valid feed did not reload");

  property p_irq_expire;
    st.en && st.mode_irq && timeout_evt |=> st.status[ST_TIMEOUT] && !st.en && !chip_reset;
  endproperty
  a_irq_expire: assert property (p_irq_expire)
    else $error("interrupt-mode time-out not flagged");

  property p_irq_bad_feed;
    st.en && st.mode_irq && bad_feed |=> st.status[ST_FEED_ERR] && !st.en && !chip_reset;
  endproperty
  a_irq_bad_feed: assert property (p_irq_bad_feed)
    else $error("interrupt-mode bad feed not flagged");

  property p_window_ok;
    st.en && good_feed && !timeout_evt |=> st.en;
  endproperty
  a_window_ok: assert property (p_window_ok)
    else $error("feed inside window was refused");

  property p_irq_level;
    irq == |(st.status & st.mask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("irq does not follow masked status");

  property p_idle_prescale;
    !st.en |=> st.pre == 2'h0;
  endproperty
  a_idle_prescale: assert property (p_idle_prescale)
    else $error("prescaler moved while disabled");

  property p_defaults_back;
    chip_reset |-> st.timeout == TIMEOUT_RST && st.count == TIMEOUT_RST && !st.mode_irq;
  endproperty
  a_defaults_back: assert property (p_defaults_back)
    else $error("configuration kept after supervisor reset");

  property p_flag_sticky;
    st.status[ST_WD_RESET]
      && !(wr && apb_req.paddr == OFF_STATUS && apb_req.pwdata[ST_WD_RESET])
      |=> st.status[ST_WD_RESET];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("reset flag lost without a clear");

  property p_mode_locked;
    st.en |=> $stable(st.mode_irq);
  endproperty
  a_mode_locked: assert property (p_mode_locked)
    else $error("mode changed while running");

endmodule
`default_nettype wire

// file: design/windowed_supervisor_pkg.sv
// Register map, constants and carriers of the windowed supervisor
`default_nettype none
package windowed_supervisor_pkg;
  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_MODE = 12'h000;
  localparam logic [11:0] OFF_TIMEOUT = 12'h004;
  localparam logic [11:0] OFF_FEED = 12'h008;
  localparam logic [11:0] OFF_COUNT = 12'h00c;
  localparam logic [11:0] OFF_WARN = 12'h010;
  localparam logic [11:0] OFF_WINDOW = 12'h014;
  localparam logic [11:0] OFF_STATUS = 12'h018;
  localparam logic [11:0] OFF_MASK = 12'h01c;
  // Mode bits
  localparam int MODE_EN = 0;
  localparam int MODE_IRQ = 1;
  // Status and mask bits
  localparam int ST_TIMEOUT = 0;
  localparam int ST_WARN = 1;
  localparam int ST_FEED_ERR = 2;
  localparam int ST_WD_RESET = 3;
  // Reset values and limits
  localparam logic [23:0] TIMEOUT_RST = 24'hffffff;
  localparam logic [23:0] TIMEOUT_MIN = 24'h0000ff;
  localparam logic [23:0] WINDOW_RST = 24'hffffff;
  localparam logic [23:0] WARN_RST = 24'h000000;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  // Feed keys, written in this order
  localparam logic [31:0] FEED_KEY1 = 32'h000000aa;
  localparam logic [31:0] FEED_KEY2 = 32'h00000055;
  // Prescaler: four oscillator edges per counter step
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic [2:0] sync;
    logic [1:0] pre;
    logic [23:0] count;
    logic [23:0] timeout;
    logic [23:0] warn;
    logic [23:0] window;
    logic en;
    logic mode_irq;
    logic armed;
    logic [3:0] status;
    logic [3:0] mask;
    apb_rsp_s rsp;
    logic irq;
    logic chip_reset;
  } sup_state_s;
endpackage
`default_nettype wire

// file: verif/windowed_supervisor_tb.sv
// Self-checking bench of the windowed supervisor over APB
`default_nettype none
module windowed_supervisor_tb import windowed_supervisor_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, resetn, osc, irq, chip_reset, err;
  logic [1:0] div;
  logic [31:0] rd;
  apb_req_s req;
  apb_rsp_s rsp;
  int fail_count, n_checks, waited;

  windowed_supervisor i_windowed_supervisor (.clk_sys(clk_sys), .resetn(resetn),
    .supervisor_oscillator(osc), .apb_req(req), .apb_rsp(rsp), .irq(irq),
    .chip_reset(chip_reset));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Oscillator at eight system cycles, free running
  always @(posedge clk_sys) begin
    div <= div + 2'h1;
    if (div == 2'h3) osc <= ~osc;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    // Answer is due one cycle after setup
    check(32'(n), 32'h1);
    req <= '0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // Waits for irq or chip_reset; irq is a level, so a stale one would end it early
  task automatic wait_evt(input logic exp_rst);
    waited = 0;
    while (irq !== 1'b1 && chip_reset !== 1'b1 && waited < 12000) begin
      @(posedge clk_sys);
      waited++;
    end
    check({31'h0, chip_reset}, {31'h0, exp_rst});
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys);
    fail_count++;
    results();
  end

  initial begin
    req = '0;
    resetn = 1'b0;
    osc = 1'b0;
    div = 2'h0;
    fail_count = 0;
    n_checks = 0;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    rdchk(OFF_MODE, 32'h0);
    rdchk(OFF_TIMEOUT, 32'h00ffffff);
    rdchk(OFF_COUNT, 32'h00ffffff);
    rdchk(OFF_WINDOW, 32'h00ffffff);
    rdchk(OFF_STATUS, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("test defaults done");
    apb(1'b1, OFF_TIMEOUT, 32'h0);
    rdchk(OFF_TIMEOUT, 32'h000000ff);
    apb(1'b1, OFF_MODE, 32'h1);
    apb(1'b1, OFF_MODE, 32'h0);
    rdchk(OFF_MODE, 32'h1);
    apb(1'b1, OFF_FEED, FEED_KEY1);
    apb(1'b1, OFF_FEED, FEED_KEY2);
    apb(1'b0, OFF_COUNT, 32'h0);
    check({rd[31:1], 1'b0}, 32'hfe);
    repeat (200) @(posedge clk_sys);
    apb(1'b0, OFF_COUNT, 32'h0);
    check({31'h0, rd < 32'hfc}, 32'h1);
    wait_evt(1'b1);
    check({31'h0, waited > 7600 && waited < 8300}, 32'h1);
    apb(1'b0, OFF_STATUS, 32'h0);
    check({31'h0, rd[ST_WD_RESET]}, 32'h1);
    rdchk(OFF_MODE, 32'h0);
    $display("test reset time-out done");
    apb(1'b1, OFF_STATUS, 32'hf);
    rdchk(OFF_STATUS, 32'h0);
    apb(1'b1, OFF_MASK, 32'hf);
    apb(1'b1, OFF_TIMEOUT, 32'hff);
    apb(1'b1, OFF_WARN, 32'hf0);
    apb(1'b1, OFF_MODE, 32'h2);
    apb(1'b1, OFF_MODE, 32'h3);
    apb(1'b1, OFF_FEED, FEED_KEY1);
    apb(1'b1, OFF_FEED, FEED_KEY2);
    wait_evt(1'b0);
    rdchk(OFF_STATUS, 32'h2);
    apb(1'b1, OFF_STATUS, 32'h2);
    rdchk(OFF_STATUS, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("test warning done");
    apb(1'b1, OFF_FEED, FEED_KEY1);
    apb(1'b0, OFF_COUNT, 32'h0);
    apb(1'b1, OFF_FEED, FEED_KEY2);
    wait_evt(1'b0);
    rdchk(OFF_STATUS, 32'h4);
    apb(1'b0, OFF_MODE, 32'h0);
    check({31'h0, rd[MODE_EN]}, 32'h0);
    $display("test feed fault done");
    apb(1'b1, OFF_STATUS, 32'hf);
    apb(1'b1, OFF_WINDOW, 32'h10);
    apb(1'b1, OFF_FEED, FEED_KEY1);
    apb(1'b1, OFF_FEED, FEED_KEY2);
    apb(1'b1, OFF_MODE, 32'h2);
    apb(1'b1, OFF_MODE, 32'h3);
    apb(1'b1, OFF_FEED, FEED_KEY1);
    apb(1'b1, OFF_FEED, FEED_KEY2);
    wait_evt(1'b0);
    rdchk(OFF_STATUS, 32'h4);
    $display("test window done");
    apb(1'b1, OFF_STATUS, 32'hf);
    apb(1'b1, OFF_MODE, 32'h3);
    // Let the counter run down into the window before feeding
    repeat (7900) @(posedge clk_sys);
    apb(1'b1, OFF_FEED, FEED_KEY1);
    apb(1'b1, OFF_FEED, FEED_KEY2);
    apb(1'b0, OFF_COUNT, 32'h0);
    check({rd[31:1], 1'b0}, 32'hfe);
    rdchk(OFF_STATUS, 32'h2);
    rdchk(OFF_MODE, 32'h3);
    $display("test window accept done");
    results();
  end
endmodule
`default_nettype wire
